/* fwseq_top.sv */
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module fwseq_top
   import fwseq_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              por_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   output      logic              core_stall,
   output      logic              flash_busy,
   output      logic              flash_erase,
   output      logic [BLK_W-1:0]  flash_block,
   output      logic [7:0]        flash_wdata,
   output      logic [HOLD_IW-1:0] flash_widx,
   output      logic              flash_wstrobe
);

   localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PROG_CYCLES - 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      fwseq_state_t                st;
      fwseq_key_t                  key;
      logic [PTR_W-1:0]            ptr;
      logic [7:0]                  latch;
      logic                        free;
      logic                        allow;
      logic                        wr;
      logic [HOLD_N-1:0][7:0]      hold;
      logic [CNT_W-1:0]            cnt;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
      logic                        stall;
      logic                        ferase;
      logic                        fstrobe;
      logic [BLK_W-1:0]            fblock;
      logic [7:0]                  fwdata;
      logic [HOLD_IW-1:0]          fwidx;
   } fwseq_regs_t;

   fwseq_regs_t        r;
   fwseq_regs_t        next_r;
   logic               acc;
   logic               wacc;
   logic               hit;
   logic [7:0]         rd_byte;
   logic               abort_flag;
   logic               start_evt;
   logic               bad_start;
   logic               done_evt;
   logic [PTR_W-1:0]   p_inc;
   logic [PTR_W-1:0]   p_dec;

   // Transfer completes on the edge that samples pready high
   assign acc  = psel & penable & r.pready;
   assign wacc = acc & pwrite;

   // Auto step touches only the low 21 bits of the pointer
   assign p_inc = {r.ptr[PTR_W-1], r.ptr[STEP_W-1:0] + STEP_W'(1)};
   assign p_dec = {r.ptr[PTR_W-1], r.ptr[STEP_W-1:0] - STEP_W'(1)};

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_byte = '0;
      hit     = 1'b1;
      unique case (paddr)
         OFS_PTR_UPPER: rd_byte[UPPER_W-1:0] = r.ptr[PTR_W-1:UPPER_LSB];
         OFS_PTR_HIGH:  rd_byte = r.ptr[15:8];
         OFS_PTR_LOW:   rd_byte = r.ptr[7:0];
         OFS_LATCH:     rd_byte = r.latch;
         OFS_KEY:       rd_byte = '0;             // Key reads as zero
         OFS_TBL_OP:    rd_byte = '0;
         OFS_CTRL:
         begin
            rd_byte[CTL_FREE] = r.free;
            rd_byte[CTL_ERR]  = abort_flag;
            rd_byte[CTL_ALLOW] = r.allow;
            rd_byte[CTL_WR]   = r.wr;
         end
         default:       hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_r         = r;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prdata  = '0;
      next_r.fstrobe = 1'b0;
      start_evt      = 1'b0;
      bad_start      = 1'b0;
      done_evt       = 1'b0;

      // Answer is withheld during a long write: this is the core stall
      if (psel && penable && !r.pready && r.st == ST_IDLE)
      begin
         next_r.pready  = 1'b1;
         next_r.pslverr = ~hit;
         next_r.prdata  = {24'h000000, rd_byte};
      end

      // Any write other than the expected key breaks the unlock chain
      if (wacc)
      begin
         next_r.key = KEY_IDLE;
         if (paddr == OFS_KEY && pwdata[7:0] == KEY_FIRST)
            next_r.key = KEY_HALF;
         else if (paddr == OFS_KEY && pwdata[7:0] == KEY_SECOND
                  && r.key == KEY_HALF)
            next_r.key = KEY_ARMED;
      end

      if (wacc)
      begin
         unique case (paddr)
            OFS_PTR_UPPER:
               next_r.ptr[PTR_W-1:UPPER_LSB] = pwdata[UPPER_W-1:0];
            OFS_PTR_HIGH:  next_r.ptr[15:8] = pwdata[7:0];
            OFS_PTR_LOW:   next_r.ptr[7:0]  = pwdata[7:0];
            OFS_LATCH:     next_r.latch     = pwdata[7:0];
            OFS_TBL_OP:
            begin
               // Short write: only one holding byte moves
               unique case (pwdata[1:0])
                  TOP_KEEP:
                     next_r.hold[r.ptr[HOLD_IW-1:0]] = r.latch;
                  TOP_POSTINC:
                  begin
                     next_r.hold[r.ptr[HOLD_IW-1:0]] = r.latch;
                     next_r.ptr = p_inc;
                  end
                  TOP_POSTDEC:
                  begin
                     next_r.hold[r.ptr[HOLD_IW-1:0]] = r.latch;
                     next_r.ptr = p_dec;
                  end
                  TOP_PREINC:
                  begin
                     next_r.hold[p_inc[HOLD_IW-1:0]] = r.latch;
                     next_r.ptr = p_inc;
                  end
               endcase
            end
            OFS_CTRL:
            begin
               next_r.free = pwdata[CTL_FREE];
               next_r.allow = pwdata[CTL_ALLOW];
               // Start only when armed and allowed
               if (pwdata[CTL_WR] && r.key == KEY_ARMED
                   && pwdata[CTL_ALLOW])
               begin
                  start_evt     = 1'b1;
                  next_r.wr     = 1'b1;
                  next_r.st     = ST_BUSY;
                  next_r.cnt    = '0;
                  next_r.stall  = 1'b1;
                  next_r.ferase = pwdata[CTL_FREE];
                  next_r.fblock = r.ptr[PTR_W-1:BLK_LSB];
               end
               else if (pwdata[CTL_WR])
                  bad_start = 1'b1;
            end
            default: ;
         endcase
      end

      // Timed long write; on a program (not erase) write, holding bytes stream out in the first 64 steps
      if (r.st == ST_BUSY)
      begin
         if (!r.ferase && r.cnt[CNT_W-1:HOLD_IW] == '0)
         begin
            next_r.fstrobe = 1'b1;
            next_r.fwidx   = r.cnt[HOLD_IW-1:0];
            next_r.fwdata  = r.hold[r.cnt[HOLD_IW-1:0]];
         end
         if (r.cnt == LAST_CNT)
         begin
            // Timer expiry is the only way out short of presetn
            done_evt      = 1'b1;
            next_r.st     = ST_IDLE;
            next_r.stall  = 1'b0;
            next_r.wr     = 1'b0;
            next_r.ferase = 1'b0;
            if (r.ferase)
               next_r.free = 1'b0;
         end
         else
            next_r.cnt = r.cnt + CNT_W'(1);
      end
   end

   // Holding bytes survive a completed write; only presetn clears them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= '0;
      else
         r <= next_r;
   end

   // ----------------------------------------------------------------
   // Abort flag lives on the power-on reset only
   // ----------------------------------------------------------------
   fwseq_abort_flag u_abort (
      .pclk    (pclk),
      .por_n   (por_n),
      .set_evt (start_evt | bad_start),
      .clr_evt (done_evt),
      .flag    (abort_flag)
   );

   assign prdata        = r.prdata;
   assign pready        = r.pready;
   assign pslverr       = r.pslverr;
   assign core_stall    = r.stall;
   assign flash_busy    = r.stall;
   assign flash_erase   = r.ferase;
   assign flash_block   = r.fblock;
   assign flash_wdata   = r.fwdata;
   assign flash_widx    = r.fwidx;
   assign flash_wstrobe = r.fstrobe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      $rose(r.stall);
   endsequence

   sequence s_done;
      $fell(r.stall);
   endsequence

   AST_START_KEYED: assert property
      (s_start |-> $past(r.key) == KEY_ARMED)
      else $error("start without unlock");
   AST_START_ALLOW: assert property
      (s_start |-> r.allow && r.wr)
      else $error("start without write allow");
   AST_BLOCK_ADDR: assert property
      (s_start |-> flash_block == $past(r.ptr[PTR_W-1:BLK_LSB])
       && flash_erase == r.free)
      else $error("wrong block or mode");
   AST_STALL_LEN: assert property
      (s_done |-> $past(r.cnt) == LAST_CNT)
      else $error("stall length wrong");
   AST_DONE_CLR: assert property
      (s_done |-> !r.wr && !r.free)
      else $error("start bit not cleared");
   AST_NO_ANSWER: assert property
      (r.stall |=> !pready)
      else $error("answer during long write");
   AST_HOLD_KEPT: assert property
      (r.st == ST_BUSY |=> r.hold == $past(r.hold))
      else $error("holding bytes changed");
   AST_STREAM: assert property
      (s_start ##0 !r.ferase |=> flash_wstrobe [*8])
      else $error("block data not streamed");
   AST_STROBE_DATA: assert property
      (flash_wstrobe |-> flash_wdata == r.hold[flash_widx])
      else $error("streamed byte mismatch");
   AST_TBL_SHORT: assert property
      (wacc && paddr == OFS_TBL_OP |=> !r.stall)
      else $error("table write stalled");
   AST_IGNORED: assert property
      (wacc && paddr == OFS_CTRL && r.key != KEY_ARMED |=> !r.stall)
      else $error("unkeyed start accepted");

endmodule : fwseq_top

/* fwseq_pkg.sv */
// ----------------------------------------------------------------
// Flash row write sequencer: shared constants
// ----------------------------------------------------------------
package fwseq_pkg;

   // Register byte offsets on the APB window
   localparam logic [7:0] OFS_PTR_UPPER = 8'h00;
   localparam logic [7:0] OFS_PTR_HIGH  = 8'h04;
   localparam logic [7:0] OFS_PTR_LOW   = 8'h08;
   localparam logic [7:0] OFS_LATCH     = 8'h0C;
   localparam logic [7:0] OFS_KEY       = 8'h10;
   localparam logic [7:0] OFS_CTRL      = 8'h14;
   localparam logic [7:0] OFS_TBL_OP    = 8'h18;

   // Unlock key values, in the order they must arrive
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // Bit positions in flash_write_control
   localparam int CTL_FREE  = 4;
   localparam int CTL_ERR   = 3;
   localparam int CTL_ALLOW = 2;
   localparam int CTL_WR    = 1;

   // Pointer and holding register geometry
   localparam int PTR_W     = 22;
   localparam int STEP_W    = 21;
   localparam int UPPER_W   = 6;
   localparam int UPPER_LSB = 16;
   localparam int BLK_LSB   = 6;
   localparam int BLK_W     = 16;
   localparam int HOLD_N    = 64;
   localparam int HOLD_IW   = 6;

   // table_write_op modes, low two bits of the op register
   localparam logic [1:0] TOP_KEEP    = 2'h0;
   localparam logic [1:0] TOP_POSTINC = 2'h1;
   localparam logic [1:0] TOP_POSTDEC = 2'h2;
   localparam logic [1:0] TOP_PREINC  = 2'h3;

   // Self-timed programming interval
   localparam int unsigned PROG_TIME_US = 2000;
   localparam int unsigned CLK_MHZ      = 200;
   localparam int          CNT_W        = 20;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_HALF  = 2'b01,
      KEY_ARMED = 2'b10
   } fwseq_key_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } fwseq_state_t;

endpackage : fwseq_pkg

/* fwseq_abort_flag.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Write-abort flag, kept across the system reset
// ----------------------------------------------------------------
module fwseq_abort_flag
   import fwseq_pkg::*;
(
   input  wire logic pclk,
   input  wire logic por_n,
   input  wire logic set_evt,
   input  wire logic clr_evt,
   output      logic flag
);

   typedef struct packed {
      logic flag;
   } fwseq_flag_t;

   fwseq_flag_t r;
   fwseq_flag_t next_r;

   // Set wins over clear; of the two resets only power-on reset clears it, so a system
   // reset cutting a write short leaves the flag up for software
   always_comb
   begin
      next_r = r;
      if (set_evt)
         next_r.flag = 1'b1;
      else if (clr_evt)
         next_r.flag = 1'b0;
   end

   always_ff @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
         r <= '0;
      else
         r <= next_r;
   end

   assign flag = r.flag;

   AST_ABORT_SET: assert property
      (@(posedge pclk) disable iff (!por_n) set_evt |=> flag)
      else $error("abort flag not set");
   AST_ABORT_CLR: assert property
      (@(posedge pclk) disable iff (!por_n)
       clr_evt && !set_evt |=> !flag)
      else $error("abort flag not cleared");

endmodule : fwseq_abort_flag

/* fwseq_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Core side: APB master issuing table and control writes
// ----------------------------------------------------------------
module fwseq_cpu_model
   import fwseq_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [7:0]  paddr,
   output      logic [31:0] pwdata
);
   // Idle bus from time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // One transfer; a stalled slave holds us until pready, no timeout of our own
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d; // Released data must not look valid
      @(posedge pclk); // Idle cycle: no signal set twice in one step
   endtask : xfer

   // Key pair then start, nothing in between
   task automatic unlock_start(input logic [7:0] ctl);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, OFS_KEY, {24'h00_0000, KEY_FIRST}, q, e);
      xfer(1'b1, OFS_KEY, {24'h00_0000, KEY_SECOND}, q, e);
      xfer(1'b1, OFS_CTRL, {24'h00_0000, ctl}, q, e);
   endtask : unlock_start
endmodule : fwseq_cpu_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import fwseq_pkg::*;
;
   localparam int PC = 100;
   logic        pclk, presetn, por_n, psel, penable, pwrite;
   logic [7:0]  paddr, flash_wdata;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, core_stall, flash_busy;
   logic        flash_erase, flash_wstrobe, er_seen;
   logic [15:0] flash_block;
   logic [5:0]  flash_widx;
   logic [7:0]  got [64];
   int          err_total, comparisons, stall_n, stb_n, busy_n;

   fwseq_top #(.PROG_CYCLES(PC)) dut (.pclk(pclk), .presetn(presetn),
      .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_stall(core_stall),
      .flash_busy(flash_busy), .flash_erase(flash_erase),
      .flash_block(flash_block), .flash_wdata(flash_wdata),
      .flash_widx(flash_widx), .flash_wstrobe(flash_wstrobe));
   fwseq_cpu_model cpu (.pclk(pclk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   // ----------------------------------------------------------------
   // Clock, reset, monitors
   // ----------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Count stall cycles and capture streamed holding bytes
   always @(posedge pclk)
   begin
      if (core_stall === 1'b1)
         stall_n++;
      if (flash_busy === 1'b1)
         busy_n++;
      if (flash_erase === 1'b1)
         er_seen = 1'b1;
      if (flash_wstrobe === 1'b1)
      begin
         got[flash_widx] = flash_wdata;
         stb_n++;
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   function automatic logic [7:0] pat(input int i);
      return 8'(i * 37 + 27);
   endfunction : pat

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      cpu.xfer(1'b1, a, {24'h00_0000, d}, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      cpu.xfer(1'b0, a, 32'h0000_0000, q, e);
      check(q, exp);
   endtask : rd

   // Long write; status read blocks until the timer ends it
   task automatic long_write(input logic [7:0] ctl, input int nstb);
      stall_n = 0;
      stb_n   = 0;
      busy_n  = 0;
      er_seen = 1'b0;
      wr(OFS_CTRL, ctl & 8'hFD);
      cpu.unlock_start(ctl);
      rd(OFS_CTRL, 32'h0000_0004);
      check(32'(stall_n), 32'(PC));
      check(32'(busy_n), 32'(PC));
      check(32'(stb_n), 32'(nstb));
      check({31'h0, er_seen}, {31'h0, ctl[4]});
      check({16'h0000, flash_block}, 32'h0000_970D);
      for (int i = 0; i < nstb; i++)
         check(32'(got[i]), 32'(pat(i)));
      $display("long write %h done", ctl);
   endtask : long_write

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_KEY, 32'h0000_0000);
      wr(OFS_PTR_UPPER, 8'hFF);
      rd(OFS_PTR_UPPER, 32'h0000_003F);
      cpu.xfer(1'b0, 8'h1C, 32'h0000_0000, q, e);
      check({q[31:1], e}, 32'h0000_0001);
      $display("register test done");
   endtask : t_regs

   // Pre-increment fill ends inside the target block
   task automatic t_load();
      wr(OFS_PTR_UPPER, 8'h25);
      wr(OFS_PTR_HIGH, 8'hC3);
      wr(OFS_PTR_LOW, 8'h3F);
      stall_n = 0;
      for (int i = 0; i < 64; i++)
      begin
         wr(OFS_LATCH, pat(i));
         wr(OFS_TBL_OP, {6'h00, TOP_PREINC});
      end
      check(32'(stall_n), 32'h0000_0000);
      wr(OFS_TBL_OP, {6'h00, TOP_KEEP});
      rd(OFS_PTR_LOW, 32'h0000_007F);
      wr(OFS_TBL_OP, {6'h00, TOP_POSTDEC});
      rd(OFS_PTR_LOW, 32'h0000_007E);
      wr(OFS_LATCH, pat(62));
      wr(OFS_TBL_OP, {6'h00, TOP_POSTINC});
      rd(OFS_PTR_LOW, 32'h0000_007F);
      $display("load test done");
   endtask : t_load

   task automatic t_refuse();
      stall_n = 0;
      wr(OFS_CTRL, 8'h06);
      rd(OFS_CTRL, 32'h0000_000C);
      wr(OFS_KEY, KEY_FIRST);
      wr(OFS_LATCH, 8'h00);
      wr(OFS_KEY, KEY_SECOND);
      wr(OFS_CTRL, 8'h06);
      wr(OFS_CTRL, 8'h00);
      cpu.unlock_start(8'h02);
      check(32'(stall_n), 32'h0000_0000);
      $display("refusal test done");
   endtask : t_refuse

   task automatic t_abort();
      wr(OFS_CTRL, 8'h04);
      cpu.unlock_start(8'h06);
      repeat (20) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_CTRL, 32'h0000_0008);
      por_n <= 1'b0;
      @(posedge pclk);
      por_n <= 1'b1;
      @(posedge pclk);
      rd(OFS_CTRL, 32'h0000_0000);
      $display("abort test done");
   endtask : t_abort

   task automatic wrap_up();
      $display("counts: %0d compared, %0d mismatched", comparisons,
               err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // Watchdog: the whole run needs little over a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      wrap_up();
   end

   // Erase precedes reprogramming from kept holding bytes
   initial
   begin
      presetn = 1'b0;
      por_n   = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      por_n   <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_load();
      long_write(8'h06, 64);
      long_write(8'h16, 0);
      long_write(8'h06, 64);
      t_refuse();
      long_write(8'h06, 64);
      t_abort();
      wrap_up();
   end
endmodule : tb_top
